// ===== adc_host_pkg.sv
// Constants, device register map and helpers for the converter host controller
//
// Operation
// - Wait 0.1 us after enable before run.
// - Never set enable and run together.
// - Change divider/length only with run clear.
// - Never set run during a conversion.
// - Write zero to mode bits 2,5,6.
// - Change resolution only when fully stopped.
// - Read result before rewriting mode or channel.
// - Rewrite channel only with run clear.
// - Keep channel register bits 7:3 zero.
// - Configure analog pin input and analog first.
package adc_host_pkg;

	// --------------------------------------------------------------
	// Device register map
	// --------------------------------------------------------------
	localparam int             DEV_AW     = 20;
	localparam logic [19:0]    GATE_ADDR  = 20'hf00f0;
	localparam logic [19:0]    MODE_ADDR  = 20'hfff30;
	localparam logic [19:0]    RES_ADDR   = 20'hf0010;
	localparam logic [19:0]    RESL_ADDR  = 20'hfff1e;
	localparam logic [19:0]    CHAN_ADDR  = 20'hfff31;
	localparam logic [7:0]     GATE_MASK  = 8'h20;
	localparam int             RUN_BIT    = 7;
	localparam int             DIVH_BIT   = 4;
	localparam int             DIVL_BIT   = 3;
	localparam int             LEN_BIT    = 1;
	localparam int             CE_BIT     = 0;
	localparam logic [7:0]     MODE_RSVD  = 8'h64;
	localparam logic [7:0]     CHAN_RSVD  = 8'hf8;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int             CLK_MHZ      = 200;
	localparam int             STAB_TIME_NS = 100;
	localparam logic [7:0]     STAB_CYCLES  = 8'((STAB_TIME_NS * CLK_MHZ + 999) / 1000);

	// --------------------------------------------------------------
	// Own registers on the AXI4-Lite side
	// --------------------------------------------------------------
	localparam logic [7:0]     CTRL_OFF       = 8'h00;
	localparam logic [7:0]     STAT_OFF       = 8'h04;
	localparam logic [7:0]     RSLT_OFF       = 8'h08;
	localparam int             CTRL_START_BIT = 0;
	localparam int             CTRL_ABORT_BIT = 1;
	localparam int             CTRL_CHAN_LSB  = 4;
	localparam int             CTRL_RES_BIT   = 8;
	localparam int             CTRL_DIV_LSB   = 12;
	localparam int             CTRL_LEN_BIT   = 16;
	localparam logic [1:0]     RESP_OKAY      = 2'b00;
	localparam logic [1:0]     RESP_SLVERR    = 2'b10;

	// Mode byte with reserved positions always zero
	function automatic logic [7:0] mode_byte(input logic run, input logic ce,
		input logic [1:0] div, input logic len);
		logic [7:0] b;
		b = 8'h00;
		b[RUN_BIT] = run;
		b[DIVH_BIT] = div[1];
		b[DIVL_BIT] = div[0];
		b[LEN_BIT] = len;
		b[CE_BIT] = ce;
		return b;
	endfunction

	// Input 0 sits on port 0 bit 7, inputs 1..7 on port 1 bits 0..6
	function automatic logic [7:0] pin_mask(input logic [2:0] ch);
		logic [7:0] m;
		m = (ch == 3'h0) ? 8'h80 : (8'h01 << (ch - 3'h1));
		return m;
	endfunction

endpackage

// ===== dev_bus_if.sv
// Request/answer channel between the sequencer and the device bus engine
interface dev_bus_if;
	import adc_host_pkg::*;
	logic              req;
	logic              we;
	logic [DEV_AW-1:0] addr;
	logic [7:0]        wdata;
	logic              ack;
	logic [7:0]        rdata;
	modport master (output req, output we, output addr, output wdata, input ack, input rdata);
	modport slave  (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// ===== dev_bus_engine.sv
// Single-access engine that drives the device's register pins
module dev_bus_engine
	import adc_host_pkg::*;
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Sequencer side
	dev_bus_if.slave                   bus,
	// Device register pins
	output logic [adc_host_pkg::DEV_AW-1:0] dev_addr,
	output logic [7:0]                 dev_wdata,
	output logic                       dev_we,
	output logic                       dev_re,
	input  wire logic [7:0]            dev_rdata
);
	import adc_host_pkg::*;

	typedef enum logic [1:0] {
		E_IDLE   = 2'b00,
		E_STROBE = 2'b01,
		E_SETTLE = 2'b10,
		E_ACK    = 2'b11
	} eng_state_t;

	eng_state_t        state_ff;
	eng_state_t        nxt_state;
	logic [DEV_AW-1:0] addr_ff;
	logic [7:0]        wdata_ff;
	logic              we_ff;
	logic              re_ff;
	logic [7:0]        rdata_ff;
	wire               launch = (state_ff == E_IDLE) && bus.req;

	always_comb
	begin
		case (state_ff)
			E_IDLE:   nxt_state = bus.req ? E_STROBE : E_IDLE;
			E_STROBE: nxt_state = E_SETTLE;
			E_SETTLE: nxt_state = E_ACK;
			E_ACK:    nxt_state = E_IDLE;
			default:  nxt_state = E_IDLE;
		endcase
	end

	// --------------------------------------------------------------
	// Strobes stand for exactly one cycle; read data is taken one
	// cycle after the read strobe
	// --------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= E_IDLE;
			addr_ff  <= '0;
			wdata_ff <= 8'h00;
			we_ff    <= 1'b0;
			re_ff    <= 1'b0;
			rdata_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			we_ff    <= launch && bus.we;
			re_ff    <= launch && !bus.we;
			if (launch)
			begin
				addr_ff  <= bus.addr;
				wdata_ff <= bus.wdata;
			end
			if (state_ff == E_SETTLE)
				rdata_ff <= dev_rdata;
		end
	end

	assign bus.ack   = (state_ff == E_ACK);
	assign bus.rdata = rdata_ff;
	assign dev_addr  = addr_ff;
	assign dev_wdata = wdata_ff;
	assign dev_we    = we_ff;
	assign dev_re    = re_ff;

endmodule

// ===== adc_host_ctrl.sv
// Host controller that runs single conversions on the converter via its registers
//
// The implementer's own choice: the AXI4-Lite slave port.
module adc_host_ctrl
	import adc_host_pkg::*;
#(
	parameter int                AXI_AW      = 8,
	parameter logic [19:0]       RESH_ADDR   = 20'hfff1f,
	parameter logic [19:0]       P0_DIR_ADDR = 20'hfff20,
	parameter logic [19:0]       P1_DIR_ADDR = 20'hfff21,
	parameter logic [19:0]       P0_ANA_ADDR = 20'hf0060,
	parameter logic [19:0]       P1_ANA_ADDR = 20'hf0061
)
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write channels
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Device register pins and finish interrupt
	output logic [adc_host_pkg::DEV_AW-1:0] dev_addr,
	output logic [7:0]             dev_wdata,
	output logic                   dev_we,
	output logic                   dev_re,
	input  wire logic [7:0]        dev_rdata,
	input  wire logic              conv_done_irq
);
	import adc_host_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0000,
		S_GATE  = 4'b0001,
		S_DIR   = 4'b0010,
		S_ANA   = 4'b0011,
		S_MODE0 = 4'b0100,
		S_RES   = 4'b0101,
		S_CHAN  = 4'b0110,
		S_CEON  = 4'b0111,
		S_STAB  = 4'b1000,
		S_RUN   = 4'b1001,
		S_WAIT  = 4'b1010,
		S_RDH   = 4'b1011,
		S_RDL   = 4'b1100,
		S_ABORT = 4'b1101
	} seq_state_t;

	dev_bus_if bus ();

	dev_bus_engine u_engine (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.bus       (bus.slave),
		.dev_addr  (dev_addr),
		.dev_wdata (dev_wdata),
		.dev_we    (dev_we),
		.dev_re    (dev_re),
		.dev_rdata (dev_rdata)
	);

	// --------------------------------------------------------------
	// AXI4-Lite slave
	// --------------------------------------------------------------
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic [2:0]  cfg_chan_ff;
	logic        cfg_res_ff;
	logic [1:0]  cfg_div_ff;
	logic        cfg_len_ff;
	logic        done_ff;
	logic        aborted_ff;
	logic        abort_pend_ff;
	logic [9:0]  result_ff;
	seq_state_t  state_ff;
	seq_state_t  nxt_state;

	function automatic logic own_reg(input logic [7:0] a);
		return (a == CTRL_OFF) || (a == STAT_OFF) || (a == RSLT_OFF);
	endfunction

	wire         wr_go    = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	wire [7:0]   waddr    = 8'(s_axi_awaddr);
	wire [7:0]   raddr    = 8'(s_axi_araddr);
	wire         wr_ctrl  = wr_go && (waddr == CTRL_OFF);
	wire         wr_known = own_reg(waddr);
	wire         rd_known = own_reg(raddr);
	wire         ar_go    = s_axi_arvalid && !rvalid_ff;
	wire         idle     = (state_ff == S_IDLE);
	wire         start    = wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[CTRL_START_BIT] && idle;
	wire         abort    = wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[CTRL_ABORT_BIT] && !idle;
	wire [31:0]  ctrl_word = {15'h0, cfg_len_ff, 2'h0, cfg_div_ff, 3'h0, cfg_res_ff,
		1'b0, cfg_chan_ff, 4'h0};
	wire [31:0]  stat_word = {29'h0, aborted_ff, done_ff, !idle};
	wire [31:0]  rd_word  = (raddr == CTRL_OFF) ? ctrl_word :
		(raddr == STAT_OFF) ? stat_word :
		(raddr == RSLT_OFF) ? {22'h0, result_ff} : 32'h0;

	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= RESP_OKAY;
		end
		else
		begin
			bvalid_ff <= wr_go || (bvalid_ff && !s_axi_bready);
			if (wr_go)
				bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
			rvalid_ff <= ar_go || (rvalid_ff && !s_axi_rready);
			if (ar_go)
			begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// --------------------------------------------------------------
	// Configuration only moves while idle, so divider, length,
	// resolution and channel never change under a running conversion
	// --------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_chan_ff <= 3'h0;
			cfg_res_ff  <= 1'b0;
			cfg_div_ff  <= 2'h0;
			cfg_len_ff  <= 1'b0;
		end
		else if (wr_ctrl && idle)
		begin
			if (s_axi_wstrb[0])
				cfg_chan_ff <= s_axi_wdata[CTRL_CHAN_LSB +: 3];
			if (s_axi_wstrb[1])
			begin
				cfg_res_ff <= s_axi_wdata[CTRL_RES_BIT];
				cfg_div_ff <= s_axi_wdata[CTRL_DIV_LSB +: 2];
			end
			if (s_axi_wstrb[2])
				cfg_len_ff <= s_axi_wdata[CTRL_LEN_BIT];
		end
	end

	// --------------------------------------------------------------
	// Conversion sequencer
	// --------------------------------------------------------------
	logic [7:0]  stab_cnt_ff;
	logic        req;
	logic        we;
	logic [19:0] addr;
	logic [7:0]  wdata;
	wire  [7:0]  pmask = pin_mask(cfg_chan_ff);
	wire         ch0   = (cfg_chan_ff == 3'h0);
	wire         ack   = bus.ack;
	logic [7:0]  mode_sh_ff;
	logic        ports_ok_ff;
	logic [7:0]  since_ce_ff;
	wire         wr_acc  = req && we && ack;
	wire         wr_mode = wr_acc && (addr == MODE_ADDR);

	assign req = (state_ff != S_IDLE) && (state_ff != S_STAB) && (state_ff != S_WAIT);
	assign we  = (state_ff != S_RDH) && (state_ff != S_RDL);

	always_comb
	begin
		case (state_ff)
			S_GATE:  addr = GATE_ADDR;
			S_DIR:   addr = ch0 ? P0_DIR_ADDR : P1_DIR_ADDR;
			S_ANA:   addr = ch0 ? P0_ANA_ADDR : P1_ANA_ADDR;
			S_RES:   addr = RES_ADDR;
			S_CHAN:  addr = CHAN_ADDR;
			S_RDH:   addr = RESH_ADDR;
			S_RDL:   addr = RESL_ADDR;
			default: addr = MODE_ADDR;
		endcase
	end

	always_comb
	begin
		case (state_ff)
			S_GATE:  wdata = GATE_MASK;
			S_DIR:   wdata = pmask;
			S_ANA:   wdata = pmask;
			S_MODE0: wdata = mode_byte(1'b0, 1'b0, cfg_div_ff, cfg_len_ff);
			S_RES:   wdata = {7'h0, cfg_res_ff};
			S_CHAN:  wdata = {5'h0, cfg_chan_ff};
			S_CEON:  wdata = mode_byte(1'b0, 1'b1, cfg_div_ff, cfg_len_ff);
			S_RUN:   wdata = mode_byte(1'b1, 1'b1, cfg_div_ff, cfg_len_ff);
			S_ABORT: wdata = mode_byte(1'b0, 1'b1, cfg_div_ff, cfg_len_ff);
			default: wdata = 8'h00;
		endcase
	end

	assign bus.req   = req;
	assign bus.we    = we;
	assign bus.addr  = addr;
	assign bus.wdata = wdata;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE:  nxt_state = start ? S_GATE : S_IDLE;
			S_GATE:  nxt_state = ack ? S_DIR : S_GATE;
			S_DIR:   nxt_state = ack ? S_ANA : S_DIR;
			S_ANA:   nxt_state = ack ? S_MODE0 : S_ANA;
			S_MODE0: nxt_state = ack ? S_RES : S_MODE0;
			S_RES:   nxt_state = ack ? S_CHAN : S_RES;
			S_CHAN:  nxt_state = ack ? S_CEON : S_CHAN;
			S_CEON:  nxt_state = ack ? S_STAB : S_CEON;
			S_STAB:  nxt_state = (stab_cnt_ff == 8'h00) ? S_RUN : S_STAB;
			S_RUN:   nxt_state = ack ? S_WAIT : S_RUN;
			// A finish seen together with an abort keeps the result
			S_WAIT:  nxt_state = conv_done_irq ? S_RDH : (abort_pend_ff ? S_ABORT : S_WAIT);
			S_RDH:   nxt_state = ack ? S_RDL : S_RDH;
			S_RDL:   nxt_state = ack ? S_IDLE : S_RDL;
			S_ABORT: nxt_state = ack ? S_IDLE : S_ABORT;
			default: nxt_state = S_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff      <= S_IDLE;
			stab_cnt_ff   <= 8'h00;
			abort_pend_ff <= 1'b0;
			done_ff       <= 1'b0;
			aborted_ff    <= 1'b0;
			result_ff     <= 10'h000;
			mode_sh_ff    <= 8'h00;
			ports_ok_ff   <= 1'b0;
			since_ce_ff   <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			if (state_ff == S_CEON)
				stab_cnt_ff <= STAB_CYCLES;
			else if (stab_cnt_ff != 8'h00)
				stab_cnt_ff <= stab_cnt_ff - 8'h01;
			abort_pend_ff <= abort || (abort_pend_ff && !idle);
			// Hardware set wins over the clear by a new start
			done_ff    <= (state_ff == S_RDL && ack) || (done_ff && !start);
			aborted_ff <= (state_ff == S_ABORT && ack) || (aborted_ff && !start);
			if (state_ff == S_RDH && ack)
				result_ff[9:2] <= bus.rdata;
			if (state_ff == S_RDL && ack)
				result_ff[1:0] <= cfg_res_ff ? 2'b00 : bus.rdata[7:6];
			// Shadow of what the device holds, for the checks below
			if (wr_mode)
				mode_sh_ff <= wdata;
			else if (conv_done_irq)
				mode_sh_ff[RUN_BIT] <= 1'b0;
			ports_ok_ff <= (state_ff == S_ANA && ack) || (ports_ok_ff && !start);
			if (wr_mode && wdata[CE_BIT] && !mode_sh_ff[CE_BIT])
				since_ce_ff <= 8'h00;
			else if (since_ce_ff != 8'hff)
				since_ce_ff <= since_ce_ff + 8'h01;
		end
	end

	// --------------------------------------------------------------
	// Checks on how the device is driven
	// --------------------------------------------------------------
	property p_stab_wait;
		@(posedge aclk) disable iff (!aresetn)
		(wr_mode && wdata[RUN_BIT]) |-> (since_ce_ff >= STAB_CYCLES);
	endproperty
	a_stab_wait: assert property (p_stab_wait)
		else $error("run set before comparator settled");
	property p_ce_first;
		@(posedge aclk) disable iff (!aresetn)
		(wr_mode && wdata[RUN_BIT]) |-> mode_sh_ff[CE_BIT];
	endproperty
	a_ce_first: assert property (p_ce_first)
		else $error("enable and run set in one write");
	property p_div_stable;
		@(posedge aclk) disable iff (!aresetn)
		(wr_mode && (wdata[RUN_BIT] != mode_sh_ff[RUN_BIT]))
			|-> (wdata[DIVH_BIT:DIVL_BIT] == mode_sh_ff[DIVH_BIT:DIVL_BIT])
			&& (wdata[LEN_BIT] == mode_sh_ff[LEN_BIT]);
	endproperty
	a_div_stable: assert property (p_div_stable)
		else $error("divider or length changed with run");
	property p_no_restart;
		@(posedge aclk) disable iff (!aresetn)
		(wr_mode && wdata[RUN_BIT]) |-> !mode_sh_ff[RUN_BIT];
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("run set during a conversion");
	property p_mode_rsvd;
		@(posedge aclk) disable iff (!aresetn)
		wr_mode |-> ((wdata & MODE_RSVD) == 8'h00);
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd)
		else $error("reserved mode bits written as one");
	property p_res_stopped;
		@(posedge aclk) disable iff (!aresetn)
		(wr_acc && addr == RES_ADDR) |-> !mode_sh_ff[RUN_BIT] && !mode_sh_ff[CE_BIT];
	endproperty
	a_res_stopped: assert property (p_res_stopped)
		else $error("resolution written while not stopped");
	property p_read_first;
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == S_WAIT && conv_done_irq)
			|=> (req && !we && addr == RESH_ADDR) [*3] ##1 (req && !we && addr == RESH_ADDR && ack);
	endproperty
	a_read_first: assert property (p_read_first)
		else $error("result not read first after finish");
	property p_chan_idle;
		@(posedge aclk) disable iff (!aresetn)
		(wr_acc && addr == CHAN_ADDR) |-> !mode_sh_ff[RUN_BIT];
	endproperty
	a_chan_idle: assert property (p_chan_idle)
		else $error("channel written while converting");
	property p_chan_rsvd;
		@(posedge aclk) disable iff (!aresetn)
		(wr_acc && addr == CHAN_ADDR) |-> ((wdata & CHAN_RSVD) == 8'h00);
	endproperty
	a_chan_rsvd: assert property (p_chan_rsvd)
		else $error("upper channel bits written as one");
	property p_pins_ready;
		@(posedge aclk) disable iff (!aresetn)
		(wr_mode && wdata[RUN_BIT]) |-> ports_ok_ff;
	endproperty
	a_pins_ready: assert property (p_pins_ready)
		else $error("run set before pin configured analog");

endmodule

// ===== adc_dev_model.sv
// Behavioural converter device on the register pins, with checks on how it is driven
module adc_dev_model
	import adc_host_pkg::*;
#(
	parameter logic [19:0] RESH_ADDR   = 20'hfff1f,
	parameter logic [19:0] P0_DIR_ADDR = 20'hfff20,
	parameter logic [19:0] P1_DIR_ADDR = 20'hfff21,
	parameter logic [19:0] P0_ANA_ADDR = 20'hf0060,
	parameter logic [19:0] P1_ANA_ADDR = 20'hf0061
)
(
	// Clock and reset
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	// Register pins
	input  wire logic [adc_host_pkg::DEV_AW-1:0] dev_addr,
	input  wire logic [7:0]                      dev_wdata,
	input  wire logic                            dev_we,
	input  wire logic                            dev_re,
	output logic [7:0]                           dev_rdata,
	// Events and misuse count
	output logic                                 conv_done_irq,
	output logic [7:0]                           fault_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// State and decode
	// ------------------------------------------------------------
	logic [7:0] gate_ff, mode_ff, res_ff, chan_ff, resh_ff, resl_ff, rsel_ff;
	logic [7:0] pdir_ff [2];
	logic [7:0] pana_ff [2];
	logic       re_d_ff, unread_ff;
	int         cnt_ff, age_ff;
	wire        run    = mode_ff[RUN_BIT];
	wire        ce     = mode_ff[CE_BIT];
	wire        psel   = |chan_ff[2:0];
	wire [7:0]  pmask  = psel ? (8'h01 << (chan_ff[2:0] - 3'h1)) : 8'h80;
	wire        pin_ok = |(pdir_ff[psel] & pana_ff[psel] & pmask);
	// Input level per channel; comparator steps are folded into the final code
	wire [9:0]  ana    = 10'h15b + 10'd97 * {7'h0, chan_ff[2:0]};
	wire [9:0]  sar    = res_ff[0] ? {ana[9:2], 2'b00} : ana;
	int         divn, nclk;
	assign divn = 8 >> mode_ff[4:3];
	assign nclk = res_ff[0] ? (mode_ff[1] ? 15 : 21) : (mode_ff[1] ? 17 : 23);
	wire        mode_w = dev_we && dev_addr == MODE_ADDR && gate_ff[5];
	wire        bad_mode = mode_w && (|(dev_wdata & MODE_RSVD)
		|| (dev_wdata[7] && (!ce || run))
		|| (|((dev_wdata ^ mode_ff) & 8'h1a) && (run || dev_wdata[7]))
		|| (dev_wdata[7] && (age_ff + 1 < STAB_CYCLES || !pin_ok))
		|| unread_ff);
	wire        bad_oth = dev_we && gate_ff[5] && ((dev_addr == RES_ADDR && (run || ce))
		|| (dev_addr == CHAN_ADDR && (run || |(dev_wdata & CHAN_RSVD) || unread_ff)));
	wire [7:0]  rmux = dev_addr == RESH_ADDR ? resh_ff : dev_addr == RESL_ADDR ? resl_ff :
		dev_addr == MODE_ADDR ? mode_ff : dev_addr == RES_ADDR ? res_ff :
		dev_addr == CHAN_ADDR ? chan_ff : 8'h00;
	// A released bus shows the inverse, so stale data never passes for an answer
	assign dev_rdata = re_d_ff ? rsel_ff : ~rsel_ff;

	// ------------------------------------------------------------
	// Registers and conversion sequencing
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{gate_ff, mode_ff, res_ff, chan_ff, resh_ff, resl_ff, rsel_ff} <= '0;
			pdir_ff <= '{8'h00, 8'h00};
			pana_ff <= '{8'h00, 8'h00};
			{re_d_ff, unread_ff, conv_done_irq} <= 3'b000;
			cnt_ff <= 0;
			age_ff <= 0;
			fault_cnt <= 8'h00;
		end
		else
		begin
			conv_done_irq <= (cnt_ff == 1);
			re_d_ff <= dev_re;
			age_ff <= ce ? age_ff + 1 : 0;
			if (bad_mode || bad_oth)
				fault_cnt <= fault_cnt + 8'h01;
			if (cnt_ff > 0)
				cnt_ff <= cnt_ff - 1;
			if (cnt_ff == 1)
			begin
				resh_ff <= sar[9:2];
				resl_ff <= {sar[1:0], 6'h00};
				mode_ff[RUN_BIT] <= 1'b0;
				unread_ff <= 1'b1;
			end
			if (dev_re)
			begin
				rsel_ff <= rmux;
				if (dev_addr == RESL_ADDR)
					unread_ff <= 1'b0;
			end
			if (dev_we)
			begin
				case (dev_addr)
					GATE_ADDR:
					begin
						gate_ff <= dev_wdata;
						if (!dev_wdata[5])
						begin
							{mode_ff, res_ff, chan_ff, resh_ff, resl_ff} <= '0;
							cnt_ff <= 0;
						end
					end
					MODE_ADDR:
					begin
						if (gate_ff[5])
						begin
							mode_ff <= {dev_wdata[7] & ce, dev_wdata[6:0]};
							if (dev_wdata[7] && ce && !run)
								cnt_ff <= divn * nclk;
							if (!dev_wdata[7])
								cnt_ff <= 0;
						end
					end
					RES_ADDR: if (gate_ff[5]) res_ff <= {7'h00, dev_wdata[0]};
					CHAN_ADDR: if (gate_ff[5]) chan_ff <= {5'h00, dev_wdata[2:0]};
					P0_DIR_ADDR: pdir_ff[0] <= dev_wdata;
					P1_DIR_ADDR: pdir_ff[1] <= dev_wdata;
					P0_ANA_ADDR: pana_ff[0] <= dev_wdata;
					P1_ANA_ADDR: pana_ff[1] <= dev_wdata;
					default: ;
				endcase
			end
		end
	end
endmodule

// ===== tb_adc_host_ctrl.sv
// Self-checking bench for the converter host controller
module tb_adc_host_ctrl
	import adc_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        aclk, aresetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, dev_wdata, dev_rdata, fault_cnt;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, dev_we, dev_re, conv_done_irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [19:0] dev_addr;
	logic [34:0] q_r [$];
	logic [1:0]  q_b [$];
	logic [34:0] ent;
	int          miscompares = 0;
	int          n_compared = 0;

	adc_host_ctrl i_adc_host_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .dev_addr, .dev_wdata, .dev_we, .dev_re, .dev_rdata,
		.conv_done_irq);
	adc_dev_model i_adc_dev_model (.aclk, .aresetn, .dev_addr, .dev_wdata, .dev_we, .dev_re,
		.dev_rdata, .conv_done_irq, .fault_cnt);

	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// ------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------
	task automatic end_sim();
		if (miscompares == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge aclk);
		q_b.push_back(er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	// With c clear the answer only steers the bench and is not compared
	task automatic rd(input logic [7:0] a, input logic c, input logic [33:0] e,
		output logic [31:0] d);
		@(posedge aclk);
		q_r.push_back({c, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask

	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready)
		begin
			ent = q_r.pop_front();
			if (ent[34]) chk({s_axi_rresp, s_axi_rdata}, ent[33:0]);
		end
		if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, q_b.pop_front()});
	end

	// One conversion; the last command lands while busy and aborts when ab is set, else must change nothing
	task automatic conv(input logic [2:0] ch, input logic r, input logic [1:0] dv,
		input logic ln, input logic ab);
		logic [31:0] cfg;
		logic [9:0]  an;
		cfg = {15'h0, ln, 2'h0, dv, 3'h0, r, 1'b0, ch, 4'h0};
		an = 10'h15b + 10'd97 * {7'h0, ch};
		wr(CTRL_OFF, cfg, 4'h7, RESP_OKAY);
		rd(CTRL_OFF, 1'b1, {RESP_OKAY, cfg}, v);
		wr(CTRL_OFF, cfg | 32'h1, 4'h7, RESP_OKAY);
		wr(CTRL_OFF, ab ? 32'h2 : 32'h71, 4'h1, RESP_OKAY);
		do
			rd(STAT_OFF, 1'b0, 34'h0, v);
		while (v[0]);
		rd(STAT_OFF, 1'b1, {RESP_OKAY, ab ? 32'h4 : 32'h2}, v);
		if (!ab) rd(RSLT_OFF, 1'b1, {RESP_OKAY, 22'h0, r ? {an[9:2], 2'b00} : an}, v);
	endtask

	// ------------------------------------------------------------
	// Test sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(32'h00db));
		rd(STAT_OFF, 1'b1, {RESP_OKAY, 32'h0}, v);
		rd(RSLT_OFF, 1'b1, {RESP_OKAY, 32'h0}, v);
		rd(8'h0c, 1'b1, {RESP_SLVERR, 32'h0}, v);
		wr(8'h10, 32'h1, 4'hf, RESP_SLVERR);
		wr(STAT_OFF, 32'hffff_ffff, 4'hf, RESP_OKAY);
		wr(CTRL_OFF, 32'h1, 4'h0, RESP_OKAY);
		rd(STAT_OFF, 1'b1, {RESP_OKAY, 32'h0}, v);
		for (int i = 0; i < 8; i++)
			conv(3'(i), i[0], 2'(i >> 1), i[0] ^ i[1], 1'b0);
		conv(3'h3, 1'b0, 2'h0, 1'b0, 1'b1);
		wr(CTRL_OFF, 32'h2, 4'h1, RESP_OKAY);
		rd(STAT_OFF, 1'b1, {RESP_OKAY, 32'h4}, v);
		repeat (4)
			conv(3'($urandom), 1'($urandom), 2'($urandom), 1'($urandom), 1'b0);
		chk({26'h0, fault_cnt}, 34'h0);
		end_sim();
	end

	initial
	begin
		// About twenty times the longest run of all scenarios together
		#200000;
		miscompares++;
		end_sim();
	end
endmodule
